//--- rtl/hp_host_port.sv
// Purpose: Host port support: clock loss guard, counter holding, interrupts
// Assumes: Host strobes synchronous to ref_clk
// Notes: One register access per host cycle
// What this block does
// - Host logic runs only while a line clock toggles.
// - Guard keeps watching both line clock inputs with a free-running clock.
// - With both clocks lost, guard acknowledges the host cycle itself.
// - I/O control bit 7 enables the guard, resets to one.
// - Eight-bit two-way data bus, one byte per host cycle.
// - Counters are 16 bits, wholly cleared on the first byte read.
// - Reading either counter byte loads the other byte into holding register.
// - Interrupts have block and source levels, each with enables and status.
// - Transmit sources: alarm message done in C-bit mode, datalink frame done.
// - Receive sources: status changes and alarm code validation or removal.
// - Receive sources: new maintenance message, parity and framing errors.
// - Default mode places interrupt registers at their listed offsets.
// - Second framing mode moves receive status to 0x14 and 0x15.
// - Active-low request asserts for any enabled condition.
// - Block status bits 7, 4, 3; disabled blocks never request.
`timescale 1ns/1ps
`default_nettype none
module hp_host_port (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Host bus
	input wire logic host_cs_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic host_cycle_ack,
	output logic host_irq_n,
	// Monitored line clocks
	input wire logic tx_input_clock,
	input wire logic rx_line_clock,
	// Framing modes
	input wire logic g832_mode,
	input wire logic cbit_mode,
	// Interrupt source events
	input wire logic [15:0] rx_status_event,
	input wire logic rx_alarm_valid,
	input wire logic rx_alarm_removed,
	input wire logic rx_path_msg,
	input wire logic tx_alarm_done,
	input wire logic tx_msg_done,
	input wire logic one_second,
	// Counter events
	input wire logic [hp_pkg::PC_NUM-1:0] perf_count_event,
	// Control out
	output logic [7:0] io_control_out
);
	typedef struct packed {
		logic [7:0] io_ctrl;
		logic [7:0] blk_en;
		logic [15:0] rx_en;
		logic [15:0] rx_stat;
		logic [7:0] rx_alarm;
		logic [7:0] rx_dl;
		logic [7:0] tx_alarm;
		logic [7:0] tx_dl;
		logic one_sec;
		logic [hp_pkg::PC_NUM-1:0][15:0] pc;
		logic [7:0] hold;
		logic [7:0] rdata;
		logic oe;
		logic done;
		logic irq_n;
	} hp_state_t;

	hp_state_t s_q;
	hp_state_t s_d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic pending;
	logic access;
	logic is_read;
	logic [7:0] pc_off;
	logic [hp_pkg::PC_IDX_W-1:0] pc_idx;

	hp_guard_if g ();

	// Reset release through two flip-flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	function automatic logic pc_hit(logic [7:0] a);
		pc_hit = (a >= hp_pkg::ADDR_PC_BASE) && (a < hp_pkg::ADDR_PC_BASE + hp_pkg::PC_SPAN);
	endfunction

	function automatic logic mix_req(logic [7:0] m);
		mix_req = m[hp_pkg::MIX_EN_BIT] && m[hp_pkg::MIX_STAT_BIT];
	endfunction

	function automatic logic alarm_req(logic [7:0] m);
		alarm_req = |(m & hp_pkg::RXA_STAT_MASK & (m >> hp_pkg::RXA_EN_SHIFT));
	endfunction

	function automatic logic [7:0] blk_status(hp_state_t st);
		blk_status = 8'h00;
		blk_status[hp_pkg::BLK_RX_BIT] = (|(st.rx_stat & st.rx_en)) || alarm_req(st.rx_alarm)
			|| mix_req(st.rx_dl);
		blk_status[hp_pkg::BLK_TX_BIT] = mix_req(st.tx_alarm) || mix_req(st.tx_dl);
		blk_status[hp_pkg::BLK_SEC_BIT] = st.one_sec;
	endfunction

	function automatic logic [7:0] read_byte(hp_state_t st, logic [7:0] a, logic g832,
		logic [hp_pkg::PC_IDX_W-1:0] idx, logic lsb);
		read_byte = 8'h00;
		if (pc_hit(a)) begin
			read_byte = lsb ? st.pc[idx][7:0] : st.pc[idx][15:8];
		end else begin
			case (a)
				hp_pkg::ADDR_IO_CTRL: read_byte = st.io_ctrl;
				hp_pkg::ADDR_BLK_EN: read_byte = st.blk_en;
				hp_pkg::ADDR_BLK_STAT: read_byte = blk_status(st);
				hp_pkg::ADDR_RX_EN_ONE: read_byte = st.rx_en[7:0];
				hp_pkg::ADDR_RX_STAT_EN_TWO: read_byte = g832 ? st.rx_en[15:8] : st.rx_stat[7:0];
				hp_pkg::ADDR_RX_STAT_ONE: read_byte = g832 ? st.rx_stat[7:0] : 8'h00;
				hp_pkg::ADDR_RX_STAT_TWO: read_byte = g832 ? st.rx_stat[15:8] : 8'h00;
				hp_pkg::ADDR_RX_ALARM: read_byte = st.rx_alarm;
				hp_pkg::ADDR_RX_DL: read_byte = st.rx_dl;
				hp_pkg::ADDR_TX_ALARM: read_byte = st.tx_alarm;
				hp_pkg::ADDR_TX_DL: read_byte = st.tx_dl;
				hp_pkg::ADDR_HOLD: read_byte = st.hold;
				default: read_byte = 8'h00;
			endcase
		end
	endfunction

	assign pending = !host_cs_n && (!host_rd_n || !host_wr_n);
	assign is_read = !host_rd_n;
	assign pc_off = host_addr - hp_pkg::ADDR_PC_BASE;
	assign pc_idx = pc_off[hp_pkg::PC_IDX_W:1];
	// No access while both line clocks are gone
	assign access = pending && !s_q.done && g.clocks_alive;

	assign g.guard_enable = s_q.io_ctrl[hp_pkg::IO_GUARD_EN_BIT];
	assign g.cycle_pending = pending;

	hp_clock_loss_guard u_guard (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tx_input_clock(tx_input_clock),
		.rx_line_clock(rx_line_clock),
		.g(g)
	);

	always_comb begin
		s_d = s_q;
		s_d.oe = !host_cs_n && !host_rd_n;
		if (!pending) begin
			s_d.done = 1'b0;
		end
		// Host access: clears first so that later sets win
		if (access) begin
			s_d.done = 1'b1;
			if (is_read) begin
				s_d.rdata = read_byte(s_q, host_addr, g832_mode, pc_idx, pc_off[0]);
				if (pc_hit(host_addr)) begin
					s_d.hold = pc_off[0] ? s_q.pc[pc_idx][15:8] : s_q.pc[pc_idx][7:0];
					s_d.pc[pc_idx] = 16'h0000;
				end else begin
					case (host_addr)
						hp_pkg::ADDR_BLK_STAT: s_d.one_sec = 1'b0;
						hp_pkg::ADDR_RX_STAT_EN_TWO: begin
							if (!g832_mode) begin
								s_d.rx_stat[7:0] = 8'h00;
							end
						end
						hp_pkg::ADDR_RX_STAT_ONE: begin
							if (g832_mode) begin
								s_d.rx_stat[7:0] = 8'h00;
							end
						end
						hp_pkg::ADDR_RX_STAT_TWO: begin
							if (g832_mode) begin
								s_d.rx_stat[15:8] = 8'h00;
							end
						end
						hp_pkg::ADDR_RX_ALARM: s_d.rx_alarm = s_q.rx_alarm & hp_pkg::RXA_EN_MASK;
						hp_pkg::ADDR_RX_DL: s_d.rx_dl = s_q.rx_dl & hp_pkg::MIX_EN_MASK;
						hp_pkg::ADDR_TX_ALARM: s_d.tx_alarm = s_q.tx_alarm & hp_pkg::MIX_EN_MASK;
						hp_pkg::ADDR_TX_DL: s_d.tx_dl = s_q.tx_dl & hp_pkg::MIX_EN_MASK;
						default: s_d.rdata = s_d.rdata;
					endcase
				end
			end else begin
				case (host_addr)
					hp_pkg::ADDR_IO_CTRL: s_d.io_ctrl = host_data_in;
					hp_pkg::ADDR_BLK_EN: s_d.blk_en = host_data_in & hp_pkg::BLK_EN_MASK;
					hp_pkg::ADDR_RX_EN_ONE: s_d.rx_en[7:0] = host_data_in;
					hp_pkg::ADDR_RX_STAT_EN_TWO: begin
						if (g832_mode) begin
							s_d.rx_en[15:8] = host_data_in;
						end
					end
					hp_pkg::ADDR_RX_ALARM: begin
						s_d.rx_alarm = (s_q.rx_alarm & hp_pkg::RXA_STAT_MASK) | (host_data_in & hp_pkg::RXA_EN_MASK);
					end
					hp_pkg::ADDR_RX_DL: begin
						s_d.rx_dl = (s_q.rx_dl & ~hp_pkg::MIX_EN_MASK) | (host_data_in & hp_pkg::MIX_EN_MASK);
					end
					hp_pkg::ADDR_TX_ALARM: begin
						s_d.tx_alarm = (s_q.tx_alarm & ~hp_pkg::MIX_EN_MASK) | (host_data_in & hp_pkg::MIX_EN_MASK);
					end
					hp_pkg::ADDR_TX_DL: begin
						s_d.tx_dl = (s_q.tx_dl & ~hp_pkg::MIX_EN_MASK) | (host_data_in & hp_pkg::MIX_EN_MASK);
					end
					default: s_d.done = 1'b1;
				endcase
			end
		end
		// Source events set sticky status
		s_d.rx_stat[7:0] = s_d.rx_stat[7:0] | rx_status_event[7:0];
		if (g832_mode) begin
			s_d.rx_stat[15:8] = s_d.rx_stat[15:8] | rx_status_event[15:8];
		end
		s_d.rx_alarm[hp_pkg::RXA_VALID_BIT] = s_d.rx_alarm[hp_pkg::RXA_VALID_BIT] || rx_alarm_valid;
		s_d.rx_alarm[hp_pkg::RXA_REMOVE_BIT] = s_d.rx_alarm[hp_pkg::RXA_REMOVE_BIT] || rx_alarm_removed;
		s_d.rx_dl[hp_pkg::MIX_STAT_BIT] = s_d.rx_dl[hp_pkg::MIX_STAT_BIT] || rx_path_msg;
		s_d.tx_alarm[hp_pkg::MIX_STAT_BIT] = s_d.tx_alarm[hp_pkg::MIX_STAT_BIT] || (tx_alarm_done && cbit_mode);
		s_d.tx_dl[hp_pkg::MIX_STAT_BIT] = s_d.tx_dl[hp_pkg::MIX_STAT_BIT] || tx_msg_done;
		s_d.one_sec = s_d.one_sec || one_second;
		// Counters count on, saturating
		for (int i = 0; i < hp_pkg::PC_NUM; i++) begin
			if (perf_count_event[i] && (s_d.pc[i] != hp_pkg::PC_MAX)) begin
				s_d.pc[i] = s_d.pc[i] + hp_pkg::PC_ONE;
			end
		end
		// Request from enabled block status
		s_d.irq_n = !(|(blk_status(s_d) & s_d.blk_en));
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.io_ctrl <= hp_pkg::IO_CTRL_RST;
			s_q.irq_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign host_data_out = s_q.rdata;
	assign host_data_oe = s_q.oe;
	assign host_cycle_ack = (s_q.done && pending) || g.force_ack;
	assign host_irq_n = s_q.irq_n;
	assign io_control_out = s_q.io_ctrl;
endmodule
`default_nettype wire

//--- rtl/hp_pkg.sv
// Purpose: Shared constants of the host port support block
// Assumes: 8-bit host address and data, 125 MHz ref_clk
// Notes: Offsets are host byte addresses
package hp_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_IO_CTRL = 8'h01;
	localparam logic [7:0] ADDR_BLK_EN = 8'h04;
	localparam logic [7:0] ADDR_BLK_STAT = 8'h05;
	localparam logic [7:0] ADDR_RX_EN_ONE = 8'h12;
	localparam logic [7:0] ADDR_RX_STAT_EN_TWO = 8'h13;
	localparam logic [7:0] ADDR_RX_STAT_ONE = 8'h14;
	localparam logic [7:0] ADDR_RX_STAT_TWO = 8'h15;
	localparam logic [7:0] ADDR_RX_ALARM = 8'h17;
	localparam logic [7:0] ADDR_RX_DL = 8'h18;
	localparam logic [7:0] ADDR_TX_ALARM = 8'h31;
	localparam logic [7:0] ADDR_TX_DL = 8'h34;
	localparam logic [7:0] ADDR_PC_BASE = 8'h50;
	localparam logic [7:0] ADDR_HOLD = 8'h6c;

	// Performance counters
	localparam int PC_NUM = 4;
	localparam int PC_IDX_W = 2;
	localparam logic [15:0] PC_MAX = 16'hffff;
	localparam logic [15:0] PC_ONE = 16'h0001;
	localparam logic [7:0] PC_SPAN = 8'h08;

	// I/O control fields and reset value
	localparam int IO_GUARD_EN_BIT = 7;
	localparam logic [7:0] IO_CTRL_RST = 8'ha0;

	// Block level fields
	localparam int BLK_RX_BIT = 7;
	localparam int BLK_TX_BIT = 4;
	localparam int BLK_SEC_BIT = 3;
	localparam logic [7:0] BLK_EN_MASK = 8'h98;

	// Mixed enable/status registers
	localparam int MIX_STAT_BIT = 0;
	localparam int MIX_EN_BIT = 1;
	localparam logic [7:0] MIX_EN_MASK = 8'h02;
	localparam int RXA_VALID_BIT = 0;
	localparam int RXA_REMOVE_BIT = 1;
	localparam int RXA_EN_SHIFT = 2;
	localparam logic [7:0] RXA_STAT_MASK = 8'h03;
	localparam logic [7:0] RXA_EN_MASK = 8'h0c;

	// Clock loss timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int LOSS_TIME_NS = 200;
	localparam int LOSS_CNT_W = 6;
	localparam logic [LOSS_CNT_W-1:0] LOSS_CYCLES = LOSS_CNT_W'((LOSS_TIME_NS * 1000) / CLK_PERIOD_PS);
endpackage

//--- rtl/hp_guard_if.sv
// Purpose: Carrier between host port and clock loss guard
// Assumes: Single ref_clk domain
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface hp_guard_if;
	logic guard_enable;
	logic cycle_pending;
	logic clocks_alive;
	logic force_ack;
	modport host (output guard_enable, output cycle_pending, input clocks_alive, input force_ack);
	modport guard (input guard_enable, input cycle_pending, output clocks_alive, output force_ack);
endinterface
`default_nettype wire

//--- rtl/hp_clock_loss_guard.sv
// Purpose: Watches both line clocks and forces the host acknowledge on loss
// Assumes: ref_clk free-runs and stands in for the ring oscillator
// Notes: Line clocks are sampled through two flip-flops
`timescale 1ns/1ps
`default_nettype none
module hp_clock_loss_guard (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Monitored clocks
	input wire logic tx_input_clock,
	input wire logic rx_line_clock,
	// Host side
	hp_guard_if.guard g
);
	typedef struct packed {
		logic tx_s1;
		logic tx_s2;
		logic tx_s3;
		logic rx_s1;
		logic rx_s2;
		logic rx_s3;
		logic [hp_pkg::LOSS_CNT_W-1:0] tx_cnt;
		logic [hp_pkg::LOSS_CNT_W-1:0] rx_cnt;
	} hp_guard_state_t;

	hp_guard_state_t s_q;
	hp_guard_state_t s_d;

	function automatic logic [hp_pkg::LOSS_CNT_W-1:0] idle_count(logic now, logic prev,
		logic [hp_pkg::LOSS_CNT_W-1:0] cnt);
		if (now != prev) begin
			idle_count = '0;
		end else if (cnt != hp_pkg::LOSS_CYCLES) begin
			idle_count = cnt + hp_pkg::LOSS_CNT_W'(1);
		end else begin
			idle_count = cnt;
		end
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.tx_s1 = tx_input_clock;
		s_d.tx_s2 = s_q.tx_s1;
		s_d.tx_s3 = s_q.tx_s2;
		s_d.rx_s1 = rx_line_clock;
		s_d.rx_s2 = s_q.rx_s1;
		s_d.rx_s3 = s_q.rx_s2;
		// Free-running watch on both inputs
		s_d.tx_cnt = idle_count(s_q.tx_s2, s_q.tx_s3, s_q.tx_cnt);
		s_d.rx_cnt = idle_count(s_q.rx_s2, s_q.rx_s3, s_q.rx_cnt);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Either clock toggling keeps the interface alive
	assign g.clocks_alive = (s_q.tx_cnt != hp_pkg::LOSS_CYCLES) || (s_q.rx_cnt != hp_pkg::LOSS_CYCLES);
	assign g.force_ack = g.guard_enable && g.cycle_pending && !g.clocks_alive;
endmodule
`default_nettype wire

//--- sim/hp_host_port_chk_monitor.sv
// Purpose: Port checker for the host port support block
// Assumes: Sees top module ports only
// Notes: Attached by bind
`timescale 1ns/1ps
`default_nettype none
module hp_host_port_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Host bus
	input wire logic host_cs_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic host_cycle_ack,
	input wire logic host_irq_n,
	// Events
	input wire logic [15:0] rx_status_event,
	input wire logic rx_alarm_valid,
	input wire logic rx_alarm_removed,
	input wire logic rx_path_msg,
	input wire logic tx_alarm_done,
	input wire logic tx_msg_done,
	input wire logic one_second,
	// Control out
	input wire logic [7:0] io_control_out
);
	// Any cause that may raise the request
	wire logic ev = (|rx_status_event) | rx_alarm_valid | rx_alarm_removed | rx_path_msg | tx_alarm_done
		| tx_msg_done | one_second | (!host_cs_n & !host_wr_n);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	AST_ACK_CYC: assert property (host_cycle_ack |-> !host_cs_n && !(host_rd_n && host_wr_n))
		else $error("ack outside a host cycle");
	AST_ACK_HOLD: assert property ((host_cycle_ack ##1 (!host_cs_n && !(host_rd_n && host_wr_n))) |-> host_cycle_ack)
		else $error("ack dropped inside a cycle");
	AST_OE_RISE: assert property ($rose(host_data_oe) |-> !$past(host_cs_n) && !$past(host_rd_n))
		else $error("bus driven without a read");
	AST_OE_WR: assert property ((!host_cs_n && !host_wr_n && host_rd_n) |=> !host_data_oe)
		else $error("bus driven during a write");
	AST_DOUT_HOLD: assert property (!host_data_oe |-> $stable(host_data_out))
		else $error("read data moved without a read");
	AST_IO_RST: assert property ($rose(reset_n) |-> io_control_out == 8'ha0)
		else $error("io control reset value wrong");
	AST_IRQ_SET: assert property ($fell(host_irq_n) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
		else $error("request without a cause");
	AST_IRQ_CLR: assert property ($rose(host_irq_n) |-> !$past(host_cs_n) || !$past(host_cs_n, 2))
		else $error("request dropped without host access");
endmodule
bind hp_host_port hp_host_port_chk i_chk (.ref_clk(ref_clk), .reset_n(reset_n), .host_cs_n(host_cs_n),
	.host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
	.host_cycle_ack(host_cycle_ack), .host_irq_n(host_irq_n), .rx_status_event(rx_status_event),
	.rx_alarm_valid(rx_alarm_valid), .rx_alarm_removed(rx_alarm_removed), .rx_path_msg(rx_path_msg),
	.tx_alarm_done(tx_alarm_done), .tx_msg_done(tx_msg_done), .one_second(one_second),
	.io_control_out(io_control_out));
`default_nettype wire

//--- sim/hp_host_model.sv
// Purpose: Host processor model on the parallel bus
// Assumes: Strobes move on rising edges
// Notes: Released data lines show inverted last value
`timescale 1ns/1ps
`default_nettype none
module hp_host_model (
	// Clock
	input wire logic clk,
	// Strobes, address, data
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] addr,
	output logic [7:0] data,
	// Device answers
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic oe
);
	initial begin
		cs_n = 1;
		rd_n = 1;
		wr_n = 1;
		addr = '0;
		data = '0;
	end
	// One byte per cycle, held until ack is seen at a rising edge or 20 edges pass without it
	task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic ok, output logic oe_seen);
		int n;
		@(posedge clk);
		cs_n <= 0;
		rd_n <= w;
		wr_n <= !w;
		addr <= a;
		data <= w ? d : ~data;
		ok = 0;
		n = 0;
		while (!ok && n < 20) begin
			@(posedge clk);
			ok = (ack === 1'b1);
			n++;
		end
		// Answer taken at the same edge that saw ack, release follows it
		q = rdata;
		oe_seen = oe;
		cs_n <= 1;
		rd_n <= 1;
		wr_n <= 1;
		data <= ~data;
	endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: Testbench of the host port support block
// Assumes: Host model drives the bus
// Notes: Line clocks stop to show the guard
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] SA [6] = '{8'h17, 8'h17, 8'h18, 8'h31, 8'h34, 8'h05};
	localparam logic [7:0] SE [6] = '{8'h01, 8'h02, 8'h01, 8'h00, 8'h01, 8'h08};
	logic ref_clk = 0, reset_n = 0, lclk_on = 1, txc = 0, rxc = 0, g832 = 0, cbit = 0;
	logic [15:0] rse = '0;
	logic [5:0] sv = '0;
	logic [3:0] pce = '0;
	logic [7:0] d;
	logic ok;
	logic oes;
	wire logic cs_n, rd_n, wr_n, oe, ack, irq_n;
	wire logic [7:0] addr, din, dout, ioc;
	int n_fail = 0, n_tests = 0;
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	always #11 if (lclk_on) txc = ~txc;
	always #13 if (lclk_on) rxc = ~rxc;
	hp_host_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .host_cs_n(cs_n), .host_rd_n(rd_n),
		.host_wr_n(wr_n), .host_addr(addr), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
		.host_cycle_ack(ack), .host_irq_n(irq_n), .tx_input_clock(txc), .rx_line_clock(rxc),
		.g832_mode(g832), .cbit_mode(cbit), .rx_status_event(rse), .rx_alarm_valid(sv[0]),
		.rx_alarm_removed(sv[1]), .rx_path_msg(sv[2]), .tx_alarm_done(sv[3]), .tx_msg_done(sv[4]),
		.one_second(sv[5]), .perf_count_event(pce), .io_control_out(ioc));
	hp_host_model i_host (.clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data(din),
		.rdata(dout), .ack(ack), .oe(oe));
	task stop_test;
		$display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		i_host.cyc(w, a, v, d, ok, oes);
		if (!ok) begin
			n_fail++;
			$display("[ERR] %0t no ack at %h", $time, a);
			stop_test();
		end
		chk({7'h00, oes}, {7'h00, !w});
	endtask
	task rr(input logic [7:0] a, input logic [7:0] e);
		acc(0, a, 8'h00);
		chk(d, e);
	endtask
	task pulse(input logic [5:0] s, input logic [15:0] r);
		@(posedge ref_clk);
		sv <= s;
		rse <= r;
		@(posedge ref_clk);
		sv <= '0;
		rse <= '0;
	endtask
	task irqc(input logic e);
		repeat (3) @(negedge ref_clk);
		chk({7'h00, irq_n}, {7'h00, e});
	endtask
	task cnt(input logic [3:0] m, input int n);
		@(posedge ref_clk);
		pce <= m;
		repeat (n) @(posedge ref_clk);
		pce <= '0;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1;
		repeat (3) @(posedge ref_clk);
		// Reset values and unmapped space
		rr(8'h01, 8'ha0);
		chk(ioc, 8'ha0);
		rr(8'h04, 8'h00);
		acc(1, 8'h7f, 8'h55);
		rr(8'h7f, 8'h00);
		// Counters through the holding register
		cnt(4'h1, 258);
		rr(8'h50, 8'h01);
		rr(8'h6c, 8'h02);
		rr(8'h51, 8'h00);
		cnt(4'h2, 5);
		rr(8'h53, 8'h05);
		rr(8'h6c, 8'h00);
		rr(8'h52, 8'h00);
		// Every single-bit source sets its status
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i, 16'h0000);
			rr(SA[i], SE[i]);
		end
		cbit <= 1;
		pulse(6'h08, 16'h0000);
		rr(8'h31, 8'h01);
		// Block enables gate the request
		acc(1, 8'h12, 8'h01);
		pulse(6'h00, 16'h0001);
		irqc(1);
		rr(8'h13, 8'h01);
		acc(1, 8'h04, 8'h80);
		pulse(6'h00, 16'h0001);
		irqc(0);
		rr(8'h13, 8'h01);
		irqc(1);
		acc(1, 8'h04, 8'h08);
		pulse(6'h20, 16'h0000);
		irqc(0);
		rr(8'h05, 8'h08);
		irqc(1);
		// Source level enables under enabled blocks
		acc(1, 8'h04, 8'h90);
		acc(1, 8'h34, 8'h02);
		pulse(6'h10, 16'h0000);
		irqc(0);
		rr(8'h34, 8'h03);
		irqc(1);
		acc(1, 8'h17, 8'h04);
		pulse(6'h01, 16'h0000);
		irqc(0);
		rr(8'h17, 8'h05);
		irqc(1);
		// Second framing mode layout
		g832 <= 1;
		pulse(6'h00, 16'h0100);
		rr(8'h15, 8'h01);
		rr(8'h14, 8'h00);
		acc(1, 8'h13, 8'h01);
		rr(8'h13, 8'h01);
		pulse(6'h00, 16'h0100);
		irqc(0);
		rr(8'h15, 8'h01);
		irqc(1);
		// Clock loss with guard on, then off
		lclk_on = 0;
		repeat (40) @(posedge ref_clk);
		i_host.cyc(0, 8'h01, 8'h00, d, ok, oes);
		chk({7'h00, ok}, 8'h01);
		lclk_on = 1;
		repeat (10) @(posedge ref_clk);
		acc(1, 8'h01, 8'h20);
		chk(ioc, 8'h20);
		lclk_on = 0;
		repeat (40) @(posedge ref_clk);
		i_host.cyc(0, 8'h01, 8'h00, d, ok, oes);
		chk({7'h00, ok}, 8'h00);
		lclk_on = 1;
		repeat (10) @(posedge ref_clk);
		rr(8'h01, 8'h20);
		stop_test();
	end
endmodule
`default_nettype wire
